// *** design/fsc_mode_ctrl.sv ***
// fail-safe system controller: mode sequencing, reset, watchdog, apb regs
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fsc_params.svh"

module fsc_mode_ctrl import fsc_pkg::*; #(
	parameter int RST_SHORT_CYC = `FSC_RST_SHORT_US * `FSC_CLK_MHZ,
	parameter int RST_LONG_CYC = `FSC_RST_LONG_US * `FSC_CLK_MHZ,
	parameter int RESTART_DLY_CYC = `FSC_RESTART_DELAY_US * `FSC_CLK_MHZ,
	parameter int WD_INIT_CYC = `FSC_WD_INIT_US * `FSC_CLK_MHZ,
	parameter int INT_RESP_CYC = `FSC_INT_RESP_US * `FSC_CLK_MHZ,
	parameter int WD_PERIOD_CYC = `FSC_WD_PERIOD_US * `FSC_CLK_MHZ,
	parameter int WD_MAX_CYC = `FSC_WD_MAX_US * `FSC_CLK_MHZ
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// monitors and wake sources
	input wire logic osc_ok,
	input wire logic lin_wake,
	input wire logic wake_pin,
	input wire logic supply_current_low,
	input wire logic supply_current_high,
	input wire logic v3_overload,
	// controlled outputs
	output logic reset_out_n,
	output logic mcu_supply_en,
	output logic inhibit_limp_oe_n,
	output logic lin_enable,
	output logic int_out_n,
	output logic switched_battery_on
);

	fsc_st_s s;
	fsc_st_s next_s;
	logic acc;
	logic wr_mode;
	logic [2:0] code;
	logic code_ok;
	logic wake_ev;
	logic [31:0] per;

	////////////////////////////////////////////////////////////////////////
	// helper: system reset into start-up with a reset source
	function automatic fsc_st_s go_reset(input fsc_st_s c,
		input logic [3:0] src, input logic lng);
		fsc_st_s r;
		r = c;
		r.mode = FSC_STARTUP;
		r.rss = src;
		r.long_rst = lng;
		r.rst_cnt = (c.cfg[`FSC_CFG_RLC] || lng) ?
			32'(RST_LONG_CYC) : 32'(RST_SHORT_CYC);
		r.wd_cnt = 32'h0;
		r.aux_cnt = 32'h0;
		r.step = 2'h0;
		r.wd_stop = 1'b0;
		r.wd_max = 1'b0;
		return r;
	endfunction : go_reset

	////////////////////////////////////////////////////////////////////////
	// bus decode and event terms
	assign acc = psel && penable && s.pready;
	assign wr_mode = acc && pwrite && (paddr == `FSC_ADDR_MODE);
	assign code = pwdata[2:0];
	// six accepted codes; 110 is accepted only inside flash mode
	assign code_ok = (code != 3'h0) &&
		((code != `FSC_CODE_LEAVE) || (s.mode == FSC_FLASH));
	assign wake_ev = lin_wake || (s.wake_q && !wake_pin);
	assign per = s.wd_max ? 32'(WD_MAX_CYC) : 32'(WD_PERIOD_CYC);

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_s = s;
		next_s.wake_q = wake_pin;
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = 1'b0;
		// counters
		if (s.rst_cnt != 32'h0) begin
			next_s.rst_cnt = s.rst_cnt - 32'h1;
		end else if (!s.wd_stop) begin
			next_s.wd_cnt = s.wd_cnt + 32'h1;
		end
		if (s.ints != 3'h0 || s.fs_wait) begin
			next_s.aux_cnt = s.aux_cnt + 32'h1;
		end
		// register writes and reads
		if (acc && pwrite && paddr == `FSC_ADDR_CONFIG) begin
			next_s.cfg = pwdata[6:0];
		end
		if (acc && !pwrite && paddr == `FSC_ADDR_INT) begin
			next_s.ints = 3'h0; // read clears; events below win
			next_s.aux_cnt = 32'h0;
		end
		// mode machine
		case (s.mode)
			FSC_STARTUP, FSC_RESTART: begin
				if (s.mode == FSC_RESTART) begin
					next_s.long_rst = 1'b1;
				end
				if (s.rst_cnt == 32'h0 && wr_mode) begin
					if (!code_ok) begin
						next_s = go_reset(next_s, `FSC_RSS_ILLEGAL,
							s.long_rst);
					end else if (s.armed && s.mode == FSC_STARTUP &&
						code == `FSC_CODE_FLASH_GO) begin
						next_s.mode = FSC_FLASH;
						next_s.armed = 1'b0;
						next_s.wd_cnt = 32'h0;
					end else if (code == `FSC_CODE_NORMAL) begin
						next_s.mode = FSC_NORMAL;
						next_s.armed = 1'b0;
						next_s.wd_cnt = 32'h0;
						next_s.long_rst = 1'b0;
					end
				end else if (s.rst_cnt == 32'h0 &&
					s.wd_cnt >= 32'(WD_INIT_CYC)) begin
					next_s.armed = 1'b0;
					if (s.mode == FSC_STARTUP) begin
						next_s = go_reset(next_s, s.rss, 1'b1);
						next_s.mode = FSC_RESTART;
					end else begin
						next_s.mode = FSC_FAILSAFE;
						next_s.long_rst = 1'b1;
					end
				end
			end
			FSC_FAILSAFE: begin
				next_s.long_rst = 1'b1;
				if (!s.fs_wait && wake_ev && osc_ok) begin
					next_s.fs_wait = 1'b1;
					next_s.aux_cnt = 32'h0;
				end else if (s.fs_wait &&
					s.aux_cnt >= 32'(RESTART_DLY_CYC)) begin
					next_s.fs_wait = 1'b0;
					next_s = go_reset(next_s, `FSC_RSS_FS_WAKE,
						1'b1);
				end
			end
			FSC_NORMAL: begin
				if (wr_mode) begin
					if (!code_ok || s.wd_cnt < (per >> 1)) begin
						next_s = go_reset(next_s, code_ok ?
							`FSC_RSS_WD_FAIL : `FSC_RSS_ILLEGAL,
							1'b0);
					end else begin
						next_s.wd_cnt = 32'h0;
						next_s.wd_off = pwdata[`FSC_MODE_WDOFF];
						if (code == `FSC_CODE_FLASH_A && s.step == 2'h2) begin
							next_s = go_reset(next_s,
								`FSC_RSS_FLASH_ENTRY, 1'b0);
							next_s.armed = 1'b1;
						end else if (code == `FSC_CODE_FLASH_A) begin
							next_s.step = 2'h1;
						end else if (code == `FSC_CODE_FLASH_B &&
							s.step == 2'h1) begin
							next_s.step = 2'h2;
						end else begin
							next_s.step = 2'h0;
						end
						if (code == `FSC_CODE_STANDBY) begin
							next_s.mode = FSC_STANDBY;
							next_s.wd_max =
								pwdata[`FSC_MODE_WDOFF];
						end else if (code == `FSC_CODE_SLEEP) begin
							next_s.mode = FSC_SLEEP;
						end
					end
				end else if (s.wd_cnt >= per) begin
					next_s = go_reset(next_s, `FSC_RSS_WD_FAIL,
						1'b0);
				end
			end
			FSC_STANDBY: begin
				if (wr_mode) begin
					if (!code_ok) begin
						next_s = go_reset(next_s, `FSC_RSS_ILLEGAL, 1'b0);
					end else begin
						next_s.wd_cnt = 32'h0;
						next_s.wd_off = pwdata[`FSC_MODE_WDOFF];
						if (code == `FSC_CODE_NORMAL) begin
							next_s.mode = FSC_NORMAL;
							next_s.wd_stop = 1'b0;
							next_s.wd_max = 1'b0;
						end else if (code == `FSC_CODE_SLEEP) begin
							next_s.mode = FSC_SLEEP;
						end
					end
				end else if (s.wd_stop) begin
					if (supply_current_high) begin
						next_s.wd_stop = 1'b0;
						next_s.wd_cnt = 32'h0;
						if (s.cfg[`FSC_CFG_RIE]) begin
							next_s.ints[`FSC_INT_WD_RESTART] = 1'b1;
						end
					end
				end else if (s.wd_cnt >= per) begin
					if (s.wd_off && supply_current_low) begin
						next_s.wd_stop = 1'b1;
					end else if (s.cfg[`FSC_CFG_TIE]) begin
						next_s.ints[`FSC_INT_WD_TMO] = 1'b1;
						next_s.cfg[`FSC_CFG_TIE] = 1'b0;
						next_s.wd_cnt = 32'h0;
					end else begin
						next_s = go_reset(next_s, `FSC_RSS_WD_FAIL, 1'b0);
					end
				end
				if (wake_ev && next_s.mode == FSC_STANDBY) begin
					if (s.cfg[`FSC_CFG_WRST]) begin
						next_s = go_reset(next_s, `FSC_RSS_WAKE,
							1'b0);
					end else begin
						next_s.ints[`FSC_INT_WAKE] = 1'b1;
					end
				end
			end
			FSC_SLEEP: begin
				if (wake_ev || (v3_overload && s.cfg[`FSC_CFG_V3_HI:
					`FSC_CFG_V3_LO] != `FSC_V3_OFF)) begin
					next_s = go_reset(next_s, `FSC_RSS_WAKE,
						1'b0);
				end else if (!s.wd_off && s.wd_cnt >= per) begin
					next_s = go_reset(next_s, `FSC_RSS_SLEEP_WD,
						1'b0);
				end
			end
			FSC_FLASH: begin
				if (wr_mode) begin
					if (code == `FSC_CODE_FLASH_A) begin
						next_s.wd_cnt = 32'h0;
					end else if (code == `FSC_CODE_LEAVE) begin
						next_s = go_reset(next_s,
							`FSC_RSS_FLASH_EXIT, 1'b0);
					end else begin
						next_s = go_reset(next_s, `FSC_RSS_ILLEGAL,
							1'b0);
					end
				end else if (s.wd_cnt >= per) begin
					next_s = go_reset(next_s, `FSC_RSS_WD_FAIL, 1'b0);
				end
			end
			default: begin
				next_s = go_reset(next_s, `FSC_RSS_ILLEGAL, 1'b1);
			end
		endcase
		// unanswered interrupt forces a reset
		if ((s.mode == FSC_NORMAL || s.mode == FSC_STANDBY) &&
			s.ints != 3'h0 && s.aux_cnt >= 32'(INT_RESP_CYC)) begin
			next_s.ints = 3'h0;
			next_s = go_reset(next_s, `FSC_RSS_INT_TMO, 1'b0);
		end
		// oscillator failure overrides every mode transition
		if (!osc_ok) begin
			next_s.mode = FSC_FAILSAFE;
			next_s.fs_wait = 1'b0;
			next_s.long_rst = 1'b1;
		end
		if (next_s.mode != FSC_NORMAL && next_s.mode != FSC_STANDBY) begin
			next_s.ints = 3'h0;
		end
		// read data
		next_s.prdata = 32'h0;
		if (psel && !pwrite) begin
			if (paddr == `FSC_ADDR_CONFIG) begin
				next_s.prdata = {25'h0, s.cfg};
			end else if (paddr == `FSC_ADDR_MODE) begin
				next_s.prdata = {28'h0, s.wd_off, 3'(s.mode)};
			end else if (paddr == `FSC_ADDR_STATUS) begin
				next_s.prdata = {22'h0, s.wd_stop, s.long_rst, s.armed,
					3'(s.mode), s.rss};
			end else if (paddr == `FSC_ADDR_INT) begin
				next_s.prdata = {29'h0, s.ints};
			end
		end
		if (paddr != `FSC_ADDR_CONFIG && paddr != `FSC_ADDR_MODE &&
			paddr != `FSC_ADDR_STATUS && paddr != `FSC_ADDR_INT) begin
			next_s.pslverr = psel && penable && !s.pready;
		end
		// pin outputs follow the coming mode
		next_s.rst_n = next_s.rst_cnt == 32'h0 &&
			next_s.mode != FSC_SLEEP &&
			next_s.mode != FSC_FAILSAFE;
		next_s.sup_en = !(next_s.mode == FSC_SLEEP ||
			(next_s.mode == FSC_FAILSAFE));
		next_s.inh_oe_n = next_s.mode == FSC_SLEEP;
		next_s.lin_en = next_s.mode == FSC_NORMAL &&
			next_s.cfg[`FSC_CFG_LMC];
		next_s.int_n = next_s.ints == 3'h0;
		next_s.v3_on = next_s.cfg[`FSC_CFG_V3_HI:`FSC_CFG_V3_LO] !=
			`FSC_V3_OFF;
	end

	////////////////////////////////////////////////////////////////////////
	// state register, one encoded mode field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.mode <= FSC_STARTUP;
			s.rst_cnt <= 32'(RST_SHORT_CYC);
			s.rss <= `FSC_RSS_POWERON;
			s.cfg <= `FSC_CFG_RESET;
			s.wake_q <= 1'b1;
			s.int_n <= 1'b1;
			s.inh_oe_n <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign reset_out_n = s.rst_n;
	assign mcu_supply_en = s.sup_en;
	assign inhibit_limp_oe_n = s.inh_oe_n;
	assign lin_enable = s.lin_en;
	assign int_out_n = s.int_n;
	assign switched_battery_on = s.v3_on;

	////////////////////////////////////////////////////////////////////////
	// checks
	osc_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		!osc_ok |=> s.mode == FSC_FAILSAFE && !reset_out_n)
		else $error("oscillator failure did not reach fail-safe");
	illegal_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_mode && code == 3'h0 && osc_ok && s.mode != FSC_FAILSAFE
		&& (s.mode != FSC_STARTUP || s.rst_cnt == 32'h0)
		|=> s.mode == FSC_STARTUP && s.rss == `FSC_RSS_ILLEGAL)
		else $error("illegal code did not reset");
	restart_long_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.mode == FSC_RESTART && osc_ok |=> s.long_rst)
		else $error("restart without long reset");
	sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.mode == FSC_SLEEP |-> !reset_out_n && !mcu_supply_en
		&& inhibit_limp_oe_n)
		else $error("sleep outputs wrong");
	lin_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s.mode == FSC_NORMAL) |-> lin_enable == s.cfg[`FSC_CFG_LMC])
		else $error("lin enabled without control bit");
	flash_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.mode == FSC_NORMAL && s.step == 2'h2 && wr_mode && osc_ok
		&& code == `FSC_CODE_FLASH_A && s.wd_cnt >= (per >> 1)
		&& s.ints == 3'h0
		|=> s.rss == `FSC_RSS_FLASH_ENTRY && s.armed && !reset_out_n)
		else $error("flash entry sequence did not reset");
	tie_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s.ints[`FSC_INT_WD_TMO]) |-> !s.cfg[`FSC_CFG_TIE]
		&& s.mode == FSC_STANDBY ##1 !int_out_n)
		else $error("timeout interrupt left enable set");
	flash_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s.mode == FSC_FLASH) |-> !s.armed
		&& $past(s.mode) == FSC_STARTUP)
		else $error("flash entered without handshake");
	rst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.rst_cnt != 32'h0 |-> !reset_out_n)
		else $error("reset released during lengthening");

endmodule : fsc_mode_ctrl

// *** dv/fsc_host_model.sv ***
// host microcontroller model: apb master that serves the controller
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_host_model import fsc_pkg::*; (
	// clock and interrupt from the controller
	input wire logic pclk,
	input wire logic int_out_n,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
////////////////////////////////////////
	// bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// one transfer, request held until pready is sampled high
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep a stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask : wr

	task rd(input logic [11:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0, q, e);
	endtask : rd

	// flash entry request, each write well inside the watchdog window
	task flash_req;
		repeat (30) @(posedge pclk);
		wr(`FSC_ADDR_MODE, {29'h0, `FSC_CODE_FLASH_A});
		repeat (30) @(posedge pclk);
		wr(`FSC_ADDR_MODE, {29'h0, `FSC_CODE_FLASH_B});
		repeat (30) @(posedge pclk);
		wr(`FSC_ADDR_MODE, {29'h0, `FSC_CODE_FLASH_A});
	endtask : flash_req

	// interrupt service: read the flags as soon as the line drops
	task ack_int(output logic [31:0] q);
		logic e;
		do @(posedge pclk); while (int_out_n !== 1'b0);
		rd(`FSC_ADDR_INT, q, e);
	endtask : ack_int
endmodule : fsc_host_model

// *** dv/test_fsc_mode_ctrl.sv ***
// self-checking testbench of the fail-safe mode controller
`timescale 1ns/1ps
`include "fsc_params.svh"
module test_fsc_mode_ctrl import fsc_pkg::*;;
	// shortened counts in cycles
	localparam int RS = 20;
	localparam int RL = 40;
	localparam int WI = 100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic osc_ok, lin_wake, wake_pin, v3_overload;
	logic supply_current_low, supply_current_high;
	logic reset_out_n, mcu_supply_en, inhibit_limp_oe_n, lin_enable;
	logic int_out_n, switched_battery_on;
	int n_mismatch = 0;
	int checked = 0;

	fsc_mode_ctrl #(.RST_SHORT_CYC(RS), .RST_LONG_CYC(RL),
		.RESTART_DLY_CYC(10), .WD_INIT_CYC(WI), .INT_RESP_CYC(60),
		.WD_PERIOD_CYC(50), .WD_MAX_CYC(80)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .osc_ok, .lin_wake, .wake_pin,
		.supply_current_low, .supply_current_high, .v3_overload,
		.reset_out_n, .mcu_supply_en, .inhibit_limp_oe_n, .lin_enable,
		.int_out_n, .switched_battery_on);
	fsc_host_model host (.pclk, .int_out_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// bounded wait for reset (s=0) or interrupt (s=1) line to reach lvl
	task wt(input logic s, input logic lvl, output int n);
		n = 0;
		while ((s ? int_out_n : reset_out_n) !== lvl && n < 500) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n < 500), 32'h1);
	endtask : wt

	// status check: mode field, and source field unless any_r is set
	task st(input fsc_mode_e m, input logic [3:0] r, input logic any_r);
		logic [31:0] q;
		logic e;
		host.rd(`FSC_ADDR_STATUS, q, e);
		chk({25'h0, q[6:4], any_r ? r : q[3:0]}, {25'h0, m, r});
	endtask : st

	task wm(input logic [2:0] c);
		host.wr(`FSC_ADDR_MODE, {29'h0, c});
	endtask : wm

	task lw;
		lin_wake <= 1'b1;
		@(posedge pclk);
		lin_wake <= 1'b0;
	endtask : lw

	// back to normal after a reset, stale flags cleared
	task up;
		int n;
		logic [31:0] q;
		logic e;
		wt(0, 1, n);
		wm(`FSC_CODE_NORMAL);
		host.rd(`FSC_ADDR_INT, q, e);
	endtask : up
////////////////////////////////////////
	task t_boot;
		int n;
		logic [31:0] q;
		logic e;
		wt(0, 1, n);
		chk(32'(n >= RS && n < RL), 32'h1);
		st(FSC_STARTUP, `FSC_RSS_POWERON, 1'b0);
		wm(`FSC_CODE_NORMAL);
		st(FSC_NORMAL, 4'h0, 1'b1);
		chk({31'h0, lin_enable}, 32'h0);
		host.wr(`FSC_ADDR_CONFIG, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, lin_enable}, 32'h1);
		host.rd(12'h010, q, e);
		chk({e, q[30:0]}, 32'h80000000);
	endtask : t_boot

	// service long before the window opens
	task t_early;
		wm(`FSC_CODE_NORMAL);
		repeat (2) @(posedge pclk);
		chk({31'h0, reset_out_n}, 32'h0);
		st(FSC_STARTUP, `FSC_RSS_WD_FAIL, 1'b0);
		up();
	endtask : t_early

	task t_illegal;
		repeat (30) @(posedge pclk);
		wm(3'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, reset_out_n}, 32'h0);
		st(FSC_STARTUP, `FSC_RSS_ILLEGAL, 1'b0);
		up();
	endtask : t_illegal

	task t_flash;
		int n;
		host.flash_req();
		repeat (2) @(posedge pclk);
		chk({31'h0, reset_out_n}, 32'h0);
		wt(0, 1, n);
		st(FSC_STARTUP, `FSC_RSS_FLASH_ENTRY, 1'b0);
		wm(`FSC_CODE_FLASH_GO);
		st(FSC_FLASH, 4'h0, 1'b1);
		wm(`FSC_CODE_FLASH_A);
		st(FSC_FLASH, 4'h0, 1'b1);
		wm(`FSC_CODE_LEAVE);
		repeat (2) @(posedge pclk);
		wt(0, 1, n);
		st(FSC_STARTUP, `FSC_RSS_FLASH_EXIT, 1'b0);
		up();
	endtask : t_flash

	// standby wake interrupt served once, then left unread
	task t_int;
		logic [31:0] q;
		logic e;
		int k;
		repeat (30) @(posedge pclk);
		wm(`FSC_CODE_STANDBY);
		st(FSC_STANDBY, 4'h0, 1'b1);
		lw();
		host.ack_int(q);
		chk(q & 32'h4, 32'h4);
		repeat (2) @(posedge pclk);
		chk({31'h0, int_out_n}, 32'h1);
		lw();
		for (k = 0; k < 5 && reset_out_n; k++) begin
			repeat (20) @(posedge pclk);
			if (reset_out_n)
				wm(`FSC_CODE_STANDBY);
		end
		st(FSC_STARTUP, `FSC_RSS_INT_TMO, 1'b0);
		up();
	endtask : t_int

	// sleep left by a wake pin edge or by watchdog overflow
	task t_sleep(input logic wake);
		int n;
		host.wr(`FSC_ADDR_CONFIG, 32'ha);
		repeat (26) @(posedge pclk);
		wm(`FSC_CODE_SLEEP);
		repeat (2) @(posedge pclk);
		chk({28'h0, reset_out_n, mcu_supply_en, inhibit_limp_oe_n,
			switched_battery_on}, 32'h3);
		if (wake)
			wake_pin <= 1'b0;
		wt(0, 1, n);
		wake_pin <= 1'b1;
		st(FSC_STARTUP, wake ? `FSC_RSS_WAKE : `FSC_RSS_SLEEP_WD, 1'b0);
		chk({31'h0, mcu_supply_en}, 32'h1);
		up();
	endtask : t_sleep

	// standby overflow with interrupt chosen: one interrupt, then reset
	task t_tie;
		int n;
		logic [31:0] q;
		logic e;
		host.wr(`FSC_ADDR_CONFIG, 32'h6);
		repeat (26) @(posedge pclk);
		wm(`FSC_CODE_STANDBY);
		host.ack_int(q);
		chk(q & 32'h2, 32'h2);
		host.rd(`FSC_ADDR_CONFIG, q, e);
		chk(q & 32'h4, 32'h0);
		wt(0, 0, n);
		st(FSC_STARTUP, `FSC_RSS_WD_FAIL, 1'b0);
		up();
	endtask : t_tie

	task t_osc;
		int n;
		osc_ok <= 1'b0;
		repeat (3) @(posedge pclk);
		st(FSC_FAILSAFE, 4'h0, 1'b1);
		lw();
		repeat (20) @(posedge pclk);
		st(FSC_FAILSAFE, 4'h0, 1'b1);
		osc_ok <= 1'b1;
		@(posedge pclk);
		lw();
		wt(0, 0, n);
		wt(0, 1, n);
		chk(32'(n >= RL), 32'h1);
		st(FSC_STARTUP, `FSC_RSS_FS_WAKE, 1'b0);
		chk({31'h0, mcu_supply_en}, 32'h1);
		up();
	endtask : t_osc

	// no start-up service at all: restart, then fail-safe
	task t_noinit;
		int n;
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		wt(0, 1, n);
		wt(0, 0, n);
		wt(0, 1, n);
		chk(32'(n >= RL), 32'h1);
		st(FSC_RESTART, 4'h0, 1'b1);
		repeat (WI + 20) @(posedge pclk);
		st(FSC_FAILSAFE, 4'h0, 1'b1);
	endtask : t_noinit
////////////////////////////////////////
	// clock at 250 MHz
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end

	// main sequence
	initial begin
		presetn = 1'b0;
		osc_ok = 1'b1;
		lin_wake = 1'b0;
		wake_pin = 1'b1;
		v3_overload = 1'b0;
		supply_current_low = 1'b0;
		supply_current_high = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_boot();
		t_early();
		t_illegal();
		t_flash();
		t_int();
		t_tie();
		t_sleep(1'b1);
		t_sleep(1'b0);
		t_osc();
		t_noinit();
		stop_test();
	end
endmodule : test_fsc_mode_ctrl

// *** include/fsc_params.svh ***
// constants of the fail-safe mode controller: offsets, fields, codes, times
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// clock rate in MHz, used to turn times into cycle counts
`define FSC_CLK_MHZ 250

// times in microseconds
`define FSC_RST_SHORT_US 1000
`define FSC_RST_LONG_US 20000
`define FSC_RESTART_DELAY_US 100
`define FSC_WD_INIT_US 64000
`define FSC_INT_RESP_US 32000
`define FSC_WD_PERIOD_US 16000
`define FSC_WD_MAX_US 256000

// register byte offsets
`define FSC_ADDR_CONFIG 12'h000
`define FSC_ADDR_MODE 12'h004
`define FSC_ADDR_STATUS 12'h008
`define FSC_ADDR_INT 12'h00c

// config fields
`define FSC_CFG_RLC 0
`define FSC_CFG_LMC 1
`define FSC_CFG_TIE 2
`define FSC_CFG_V3_LO 3
`define FSC_CFG_V3_HI 4
`define FSC_CFG_RIE 5
`define FSC_CFG_WRST 6
`define FSC_CFG_RESET 7'h00

// mode register fields
`define FSC_MODE_WDOFF 3

// operating mode codes
`define FSC_CODE_FLASH_A 3'h7
`define FSC_CODE_FLASH_B 3'h1
`define FSC_CODE_FLASH_GO 3'h3
`define FSC_CODE_NORMAL 3'h5
`define FSC_CODE_LEAVE 3'h6
`define FSC_CODE_STANDBY 3'h4
`define FSC_CODE_SLEEP 3'h2

// switched battery output settings
`define FSC_V3_OFF 2'h0

// reset source codes
`define FSC_RSS_POWERON 4'h0
`define FSC_RSS_WD_FAIL 4'h2
`define FSC_RSS_INT_TMO 4'h3
`define FSC_RSS_WAKE 4'h4
`define FSC_RSS_FLASH_EXIT 4'h5
`define FSC_RSS_FLASH_ENTRY 4'h6
`define FSC_RSS_ILLEGAL 4'h7
`define FSC_RSS_SLEEP_WD 4'h8
`define FSC_RSS_SUPPLY_I 4'h9
`define FSC_RSS_FS_WAKE 4'ha

// interrupt flag positions
`define FSC_INT_WD_RESTART 0
`define FSC_INT_WD_TMO 1
`define FSC_INT_WAKE 2

`endif

// *** include/fsc_pkg.sv ***
// types of the fail-safe mode controller
package fsc_pkg;

	typedef enum logic [2:0] {
		FSC_STARTUP,
		FSC_RESTART,
		FSC_FAILSAFE,
		FSC_NORMAL,
		FSC_STANDBY,
		FSC_SLEEP,
		FSC_FLASH
	} fsc_mode_e;

	typedef struct packed {
		fsc_mode_e mode;
		logic [31:0] rst_cnt;
		logic [31:0] wd_cnt;
		logic [31:0] aux_cnt;
		logic fs_wait;
		logic long_rst;
		logic [6:0] cfg;
		logic wd_off;
		logic wd_stop;
		logic wd_max;
		logic [3:0] rss;
		logic armed;
		logic [1:0] step;
		logic [2:0] ints;
		logic wake_q;
		logic rst_n;
		logic sup_en;
		logic inh_oe_n;
		logic lin_en;
		logic int_n;
		logic v3_on;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} fsc_st_s;

endpackage : fsc_pkg
